// *** design/flash_port_pkg.sv ***
// package: constants, states and carrier structs for the flash parallel port
package flash_port_pkg;

    // ==========================================================
    // array geometry
    localparam int ARRAY_WORDS = 512;              // words in the user flash array
    localparam int ARRAY_AW = 9;                   // full word address width
    localparam int WORD_W = 16;                    // stored word width
    localparam int DATA_W_MIN = 3;                 // narrowest data port
    localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff; // erased cell value
    localparam logic [WORD_W-1:0] PAD_ONES = 16'hffff;    // low-bit fill

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;             // 50 mhz clock
    localparam int READ_TIME_NS = 100;             // array read time
    localparam int WRITE_TIME_NS = 1000;           // word program time
    localparam int ERASE_TIME_NS = 2000;           // word erase time
    localparam int READ_CYC = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;                      // wait counter width
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;  // counter step

    // ==========================================================
    // operation states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_ERASE = 4'b1000
    } op_state_t;

    // ==========================================================
    // carrier: request bundle from the outside logic
    typedef struct packed {
        logic read_request_low;   // active-low read
        logic write_request_low;  // active-low write
        logic erase_request_low;  // active-low erase
    } req_t;

    // carrier: one array access
    typedef struct packed {
        logic we;                 // store word
        logic [ARRAY_AW-1:0] addr; // word address
        logic [WORD_W-1:0] wdata; // word to store
    } mem_cmd_t;

endpackage

// *** design/flash_array_mem.sv ***
// user flash storage array with registered read data
`timescale 1ns/1ps
module flash_array_mem (
    input wire logic mclk_i,                         // system clock
    input wire flash_port_pkg::mem_cmd_t cmd_i,      // access this cycle
    output logic [flash_port_pkg::WORD_W-1:0] rdata_o // registered read word
);
    import flash_port_pkg::*;

    // ==========================================================
    // storage; no reset since flash holds content, starts erased
    logic [WORD_W-1:0] mem [ARRAY_WORDS]; // the array
    logic [WORD_W-1:0] rdata_ff;          // read register

    initial begin
        for (int i = 0; i < ARRAY_WORDS; i++) begin
            mem[i] = ERASED_WORD;
        end
    end

    // write or read one word per cycle
    always_ff @(posedge mclk_i) begin
        if (cmd_i.we) begin
            mem[cmd_i.addr] <= cmd_i.wdata;
        end
        rdata_ff <= mem[cmd_i.addr];
    end

    assign rdata_o = rdata_ff;

endmodule // flash_array_mem

// *** design/flash_parallel_port.sv ***
// parallel request port in front of the user flash array
// Behaviour
// - one low request starts that operation
// - busy low while operation in progress
// - busy returns high when operation finishes
// - requests ignored while busy is low
// - data valid high after read completes
// - multiple requests together are all ignored
// - one word per request, no bursts
// - write data width parameter 3 to 16
// - read data width parameter 3 to 16
// - operations act on addressed word
// - address width parameter at most 9
// - build option read/write or read-only
// - array holds 512 sixteen-bit words
// - narrow data in msbs, low bits ones
`timescale 1ns/1ps
module flash_parallel_port #(
    parameter int DATA_W = 16,          // data port width, 3..16
    parameter int ADDR_W = 9,           // address width, 1..9
    parameter bit READ_ONLY = 1'b0      // 1: write and erase disabled
) (
    input wire logic mclk_i,                        // 50 mhz clock
    input wire logic reset_n_i,                     // async reset, active low
    input wire flash_port_pkg::req_t req_i,         // active-low requests
    input wire logic [ADDR_W-1:0] addr_i,           // word address
    input wire logic [DATA_W-1:0] write_data_in_i,  // write word
    output logic [DATA_W-1:0] read_data_o,          // read word
    output logic busy_n_o,                          // low while working
    output logic data_valid_o                       // read data valid
);
    import flash_port_pkg::*;

    // ==========================================================
    // build-time checks on widths
    initial begin
        if (DATA_W < DATA_W_MIN || DATA_W > WORD_W) begin
            $error("data width out of range");
        end
        if (ADDR_W < 1 || ADDR_W > ARRAY_AW) begin
            $error("address width out of range");
        end
    end

    // ==========================================================
    // request decode
    // count of active-low requests; only exactly one is accepted
    function automatic logic one_hot_req(input req_t r);
        logic [1:0] n;
        n = 2'(!r.read_request_low) + 2'(!r.write_request_low) + 2'(!r.erase_request_low);
        return n == 2'h1;
    endfunction

    logic req_one;      // exactly one request low
    logic rd_go;        // accept read
    logic wr_go;        // accept write
    logic er_go;        // accept erase
    logic allow_mod;    // array may be modified

    assign allow_mod = !READ_ONLY;
    assign req_one = one_hot_req(req_i);
    assign rd_go = req_one && !req_i.read_request_low;
    // read-only build drops write and erase entirely
    assign wr_go = req_one && !req_i.write_request_low && allow_mod;
    assign er_go = req_one && !req_i.erase_request_low && allow_mod;

    // ==========================================================
    // state, counter, latched operands
    op_state_t state_ff, nxt_state;           // operation state
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;        // cycles left in op
    logic [ARRAY_AW-1:0] addr_ff, nxt_addr;   // latched word address
    logic [WORD_W-1:0] wdata_ff, nxt_wdata;   // latched padded word
    logic busy_n_ff, nxt_busy_n;              // busy flag
    logic valid_ff, nxt_valid;                // data valid flag
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;   // read output register
    logic [WORD_W-1:0] mem_rdata;             // array read word
    mem_cmd_t mem_cmd;                        // array access

    // pad a narrow word into the msbs, fill low bits with ones
    function automatic logic [WORD_W-1:0] pad_word(input logic [DATA_W-1:0] d);
        logic [WORD_W-1:0] w;
        w = PAD_ONES;
        w[WORD_W-1 -: DATA_W] = d;
        return w;
    endfunction

    // next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_busy_n = busy_n_ff;
        nxt_valid = valid_ff;
        nxt_rdata = rdata_ff;
        case (state_ff)
            ST_IDLE: begin
                // address zero-extended: narrow builds see the low words
                nxt_addr = ARRAY_AW'(addr_i);
                nxt_wdata = pad_word(write_data_in_i);
                if (rd_go || wr_go || er_go) begin
                    nxt_busy_n = 1'b0;
                    nxt_valid = 1'b0;
                end
                if (rd_go) begin
                    nxt_state = ST_READ;
                    nxt_cnt = CNT_W'(READ_CYC);
                end else if (wr_go) begin
                    nxt_state = ST_WRITE;
                    nxt_cnt = CNT_W'(WRITE_CYC);
                end else if (er_go) begin
                    nxt_state = ST_ERASE;
                    nxt_cnt = CNT_W'(ERASE_CYC);
                end
            end
            ST_READ, ST_WRITE, ST_ERASE: begin
                // requests are not looked at here at all
                nxt_cnt = cnt_ff - CNT_ONE;
                if (cnt_ff == CNT_ONE) begin
                    nxt_state = ST_IDLE;
                    nxt_busy_n = 1'b1;
                    if (state_ff == ST_READ) begin
                        // only the msbs carry user data
                        nxt_rdata = mem_rdata[WORD_W-1 -: DATA_W];
                        nxt_valid = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_busy_n = 1'b1;
            end
        endcase
    end

    // registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            addr_ff <= '0;
            wdata_ff <= '0;
            busy_n_ff <= 1'b1;
            valid_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            busy_n_ff <= nxt_busy_n;
            valid_ff <= nxt_valid;
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // array access: single word, stored at the last busy cycle
    always_comb begin
        mem_cmd.addr = addr_ff;
        mem_cmd.we = (state_ff == ST_WRITE || state_ff == ST_ERASE) && cnt_ff == CNT_ONE;
        mem_cmd.wdata = (state_ff == ST_ERASE) ? ERASED_WORD : wdata_ff;
    end

    // 512 x 16 storage
    flash_array_mem u_array (
        .mclk_i(mclk_i),
        .cmd_i(mem_cmd),
        .rdata_o(mem_rdata)
    );

    assign read_data_o = rdata_ff;
    assign busy_n_o = busy_n_ff;
    assign data_valid_o = valid_ff;

    // ==========================================================
    // assertions
    localparam int RD_LAT = READ_CYC + 1;  // accept edge to busy release

    sequence s_read_accept;
        state_ff == ST_IDLE && rd_go;
    endsequence

    sequence s_busy_window;
        !busy_n_o [*1];
    endsequence

    property p_busy_on_accept;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_ff == ST_IDLE && (rd_go || wr_go || er_go)) |=> !busy_n_o;
    endproperty
    a_busy_on_accept: assert property (p_busy_on_accept) else $error("busy not raised");

    property p_read_release;
        @(posedge mclk_i) disable iff (!reset_n_i)
        s_read_accept |=> s_busy_window ##(RD_LAT - 1) (busy_n_o && data_valid_o);
    endproperty
    a_read_release: assert property (p_read_release) else $error("read not done in time");

    property p_multi_ignored;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_ff == ST_IDLE && !req_one) |=> busy_n_o && !mem_cmd.we;
    endproperty
    a_multi_ignored: assert property (p_multi_ignored) else $error("bad request taken");

    property p_busy_ignores;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (!busy_n_o && cnt_ff != CNT_ONE) |=> !busy_n_o && $stable(addr_ff);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("request taken while busy");

    property p_ro_no_write;
        @(posedge mclk_i) disable iff (!reset_n_i)
        READ_ONLY |-> !mem_cmd.we && !(state_ff == ST_WRITE || state_ff == ST_ERASE);
    endproperty
    a_ro_no_write: assert property (p_ro_no_write) else $error("read-only array modified");

    property p_valid_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_ff == ST_IDLE && (rd_go || wr_go || er_go)) |=> !data_valid_o;
    endproperty
    a_valid_clear: assert property (p_valid_clear) else $error("valid not cleared");

    property p_valid_only_idle;
        @(posedge mclk_i) disable iff (!reset_n_i)
        data_valid_o |-> busy_n_o;
    endproperty
    a_valid_only_idle: assert property (p_valid_only_idle) else $error("valid while busy");

    property p_write_once;
        @(posedge mclk_i) disable iff (!reset_n_i)
        mem_cmd.we |=> !mem_cmd.we && busy_n_o;
    endproperty
    a_write_once: assert property (p_write_once) else $error("more than one word stored");

    property p_erase_time;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_ff == ST_IDLE && er_go) |=> !busy_n_o [*8];
    endproperty
    a_erase_time: assert property (p_erase_time) else $error("erase ended early");

endmodule // flash_parallel_port

// *** verif/flash_host_model.sv ***
// behavioural outside logic that issues requests to the flash parallel port
`timescale 1ns/1ps
module flash_host_model (
    input wire logic mclk_i,                // system clock
    input wire logic busy_n_i,              // busy flag from the port
    output flash_port_pkg::req_t req_o,     // active-low requests
    output logic [8:0] addr_o,              // word address
    output logic [15:0] wdata_o             // write word
);
    import flash_port_pkg::*;
    // ==========================================================
    // idle state: no request pending
    initial begin
        req_o = req_t'(3'b111);
        addr_o = 9'h000;
        wdata_o = 16'h0000;
    end
    // ==========================================================
    // present one request pattern for exactly one edge, then release
    task automatic start(input logic [2:0] r, input logic [8:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        #1;
        req_o = req_t'(r);
        addr_o = a;
        wdata_o = d;
        @(posedge mclk_i);
        #1;
        req_o = req_t'(3'b111);  // levels are re-taken, so drop them at once
        addr_o = ~a;             // released lines must not keep the old word
        wdata_o = ~d;
    endtask
    // count edges until busy reads high; bounded so a hang cannot stall
    task automatic wait_idle(output int cyc);
        cyc = 0;
        do begin
            @(posedge mclk_i);
            #1;
            cyc++;
        end while (busy_n_i !== 1'b1 && cyc < 300);
    endtask
endmodule // flash_host_model

// *** verif/tb_top.sv ***
// self-checking testbench for the flash parallel port, full and read-only builds
`timescale 1ns/1ps
module tb_top;
    import flash_port_pkg::*;
    // ==========================================================
    // request patterns, active low {read, write, erase}
    localparam logic [2:0] RD = 3'b011;
    localparam logic [2:0] WR = 3'b101;
    localparam logic [2:0] ER = 3'b110;
    logic mclk_i = 1'b0; // system clock
    logic reset_n_i = 1'b0; // async reset, active low
    req_t req_a, req_b; // requests per build
    logic [8:0] addr_a, addr_b; // host addresses
    logic [15:0] wd_a, wd_b; // host write words
    logic [15:0] rd_a; // read word, full build
    logic [7:0] rd_b; // read word, narrow build
    logic busy_a, busy_b, valid_a, valid_b; // status flags
    int failures = 0; // mismatches seen
    int comparisons = 0; // checks made
    always #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
    // ==========================================================
    // full width read/write build and its host
    flash_parallel_port u_flash_parallel_port (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .req_i(req_a), .addr_i(addr_a), .write_data_in_i(wd_a), .read_data_o(rd_a),
        .busy_n_o(busy_a), .data_valid_o(valid_a));
    flash_host_model u_flash_host_model (.mclk_i(mclk_i), .busy_n_i(busy_a),
        .req_o(req_a), .addr_o(addr_a), .wdata_o(wd_a));
    // narrow read-only build: 8 data bits, 3 address bits
    flash_parallel_port #(.DATA_W(8), .ADDR_W(3), .READ_ONLY(1'b1)) u_flash_parallel_port_ro (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req_b), .addr_i(addr_b[2:0]),
        .write_data_in_i(wd_b[15:8]), .read_data_o(rd_b), .busy_n_o(busy_b),
        .data_valid_o(valid_b));
    flash_host_model u_flash_host_model_ro (.mclk_i(mclk_i), .busy_n_i(busy_b),
        .req_o(req_b), .addr_o(addr_b), .wdata_o(wd_b));
    // ==========================================================
    // compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one request through a host, judged on its busy length
    // wait_idle starts one edge after acceptance, so it sees busy low for
    // exactly the op's cycle count; a refused request gives a count of 1
    task automatic op(input bit ro, input logic [2:0] r, input logic [8:0] a,
                      input logic [15:0] d, input int exp_cyc);
        int cyc;
        if (ro) begin
            u_flash_host_model_ro.start(r, a, d);
            u_flash_host_model_ro.wait_idle(cyc);
        end else begin
            u_flash_host_model.start(r, a, d);
            u_flash_host_model.wait_idle(cyc);
        end
        check("busy cycles", 16'(cyc), 16'(exp_cyc));
    endtask
    // ==========================================================
    // scenarios
    task automatic t_write_read();
        op(1'b0, WR, 9'h1ff, 16'ha5c3, WRITE_CYC);
        op(1'b0, WR, 9'h000, 16'h3c5a, WRITE_CYC);
        op(1'b0, RD, 9'h1ff, 16'h0000, READ_CYC);
        check("read top word", rd_a, 16'ha5c3);
        check("valid after read", 16'(valid_a), 16'h0001);
        op(1'b0, RD, 9'h1fe, 16'h0000, READ_CYC);
        check("neighbour untouched", rd_a, 16'hffff);
        op(1'b0, RD, 9'h000, 16'h0000, READ_CYC);
        check("read bottom word", rd_a, 16'h3c5a);
    endtask
    // a read offered while a write runs must leave no trace
    task automatic t_busy_ignore();
        int cyc;
        u_flash_host_model.start(WR, 9'h010, 16'h1234);
        u_flash_host_model.start(RD, 9'h1ff, 16'h0000);
        u_flash_host_model.wait_idle(cyc);
        // the refused read uses up two of the write's busy edges before counting
        check("busy span with ignored read", 16'(cyc), 16'(WRITE_CYC - 2));
        check("valid cleared by write", 16'(valid_a), 16'h0000);
        op(1'b0, RD, 9'h010, 16'h0000, READ_CYC);
        check("word from busy write", rd_a, 16'h1234);
    endtask
    // every double and triple request is refused outright
    task automatic t_multi();
        logic [2:0] combos [4] = '{3'b001, 3'b010, 3'b100, 3'b000};
        foreach (combos[i]) begin
            op(1'b0, combos[i], 9'h010, 16'h0000, 1);
        end
        check("valid kept after refusals", 16'(valid_a), 16'h0001);
        op(1'b0, RD, 9'h010, 16'h0000, READ_CYC);
        check("word after refusals", rd_a, 16'h1234);
    endtask
    // erase of one word, read back as all ones
    task automatic t_erase();
        op(1'b0, ER, 9'h1ff, 16'h0000, ERASE_CYC);
        op(1'b0, RD, 9'h1ff, 16'h0000, READ_CYC);
        check("erased word", rd_a, ERASED_WORD);
        op(1'b0, RD, 9'h010, 16'h0000, READ_CYC);
        check("other word kept", rd_a, 16'h1234);
    endtask
    // read-only narrow build refuses write and erase
    task automatic t_read_only();
        op(1'b1, WR, 9'h007, 16'h0000, 1);
        op(1'b1, ER, 9'h007, 16'h0000, 1);
        op(1'b1, RD, 9'h007, 16'h0000, READ_CYC);
        check("narrow read msbs", 16'(rd_b), 16'h00ff);
        check("narrow valid", 16'(valid_b), 16'h0001);
    endtask
    // ==========================================================
    // verdict in one place
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #100000;
        failures++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        check("busy after reset", 16'(busy_a), 16'h0001);
        check("valid after reset", 16'(valid_a), 16'h0000);
        t_write_read();
        t_busy_ignore();
        t_multi();
        t_erase();
        t_read_only();
        conclude();
    end
endmodule // tb_top
